// *** core/cpudp_top.sv ***
// Processor datapath: registers, busses, arithmetic unit and sequencing.
`timescale 1ns/1ps
module cpudp_top
   import cpudp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   output logic [15:0] mem_addr,
   input wire logic [15:0] mem_data_in,
   output logic [15:0] mem_data_out,
   output logic mem_data_oe,
   output logic mem_req,
   output logic mem_we,
   input wire logic mem_done,
   input wire logic [15:0] io_in,
   output logic [15:0] io_out,
   output logic io_strobe,
   output logic [15:0] display,
   output logic overflow,
   output logic halted
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      cpudp_state_t st;
      logic [15:0] u;
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] x;
      logic [15:0] p;
      logic [15:0] l;
      logic [15:0] w;
      logic [15:0] r;
      logic ov;
      logic req;
      logic we;
      logic oe;
      logic [15:0] io_out;
      logic io_stb;
      logic [15:0] disp;
      logic [15:0] d1;
      logic [15:0] d2;
      logic k1;
      logic k2;
      logic [15:0] e1;
      logic [15:0] e2;
      logic hlt;
   } cpudp_core_t;

   cpudp_core_t q_reg;
   cpudp_core_t q_next;

   logic tick;
   logic sc_load;
   logic [SC_W-1:0] sc_val;
   logic sc_step;
   logic [SC_W-1:0] sc_count;
   logic sc_zero;

   // Combinational busses and decode.
   logic [3:0] op;
   logic [2:0] mode;
   logic [2:0] sub;
   logic [15:0] disp9;
   logic [15:0] ea;
   logic [15:0] s_bus;
   logic [15:0] c_bus;
   logic [16:0] sum;
   logic [16:0] diff;
   logic [15:0] as;
   logic [15:0] bs;

   // -------------------------------------------------------------------
   // Timing and shift counter
   // -------------------------------------------------------------------
   cpudp_timing u_timing (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .tick(tick)
   );

   cpudp_shcnt u_shcnt (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .load(sc_load),
      .load_val(sc_val),
      .step(sc_step),
      .count(sc_count),
      .zero(sc_zero)
   );

   // -------------------------------------------------------------------
   // Decode and effective address
   // -------------------------------------------------------------------
   // The decode reads the held instruction only, so memory traffic that
   // overwrites the buffer register never disturbs control.
   assign op = q_reg.u[OPF_HI:OPF_LO];
   assign mode = q_reg.u[MF_HI:MF_LO];
   assign sub = q_reg.u[SUBF_HI:SUBF_LO];
   assign disp9 = {7'h00, q_reg.u[ADF_HI:0]};

   // The address adder is purely combinational, so relative and indexed
   // forms complete in the same decode cycle as direct addresses.
   always_comb begin
      unique case (mode)
         AM_REL: ea = q_reg.p + disp9;
         AM_IDX_X: ea = q_reg.x + disp9;
         AM_IDX_B: ea = q_reg.b + disp9;
         default: ea = disp9;
      endcase
   end

   // -------------------------------------------------------------------
   // Sequencer and datapath
   // -------------------------------------------------------------------
   always_comb begin
      q_next = q_reg;
      sc_load = 1'b0;
      sc_val = SC_RST;
      sc_step = 1'b0;
      s_bus = q_reg.a;
      c_bus = q_reg.disp;
      sum = 17'h0_0000;
      diff = 17'h0_0000;
      as = WORD_RST;
      bs = WORD_RST;
      // Pins from outside the clock domain pass two flip-flops.
      q_next.d1 = mem_data_in;
      q_next.d2 = q_reg.d1;
      q_next.k1 = mem_done;
      q_next.k2 = q_reg.k1;
      q_next.e1 = io_in;
      q_next.e2 = q_reg.e1;
      q_next.io_stb = 1'b0;
      if (tick) begin
         unique case (q_reg.st)
            ST_FETCH: begin
               // A new access starts only after memory dropped done.
               if (!q_reg.k2) begin
                  s_bus = q_reg.p;
                  sum = {1'b0, s_bus} + 17'h0_0001;
                  q_next.l = q_reg.p;
                  q_next.p = sum[15:0];
                  q_next.req = 1'b1;
                  q_next.we = 1'b0;
                  q_next.oe = 1'b0;
                  q_next.st = ST_FWAIT;
               end
            end
            ST_FWAIT: begin
               if (q_reg.k2) begin
                  q_next.w = q_reg.d2;
                  q_next.req = 1'b0;
                  q_next.st = ST_FLOAD;
               end
            end
            ST_FLOAD: begin
               q_next.u = q_reg.w;
               q_next.st = ST_DEC;
            end
            ST_DEC: begin
               unique case (op)
                  OP_JMP: begin
                     q_next.p = ea;
                     q_next.st = ST_FETCH;
                  end
                  OP_JOF: begin
                     if (q_reg.ov) begin
                        q_next.p = ea;
                        q_next.ov = 1'b0;
                     end
                     q_next.st = ST_FETCH;
                  end
                  OP_STA: begin
                     s_bus = q_reg.a;
                     c_bus = s_bus;
                     q_next.l = ea;
                     q_next.w = c_bus;
                     q_next.req = 1'b1;
                     q_next.we = 1'b1;
                     q_next.oe = 1'b1;
                     q_next.st = ST_SWAIT;
                  end
                  OP_SHF: begin
                     sc_load = 1'b1;
                     sc_val = q_reg.u[CNTF_HI:0];
                     q_next.st = ST_SHIFT;
                  end
                  OP_IOA: begin
                     if (q_reg.u[DIR_BIT]) begin
                        s_bus = q_reg.a;
                        c_bus = s_bus;
                        q_next.io_out = c_bus;
                        q_next.io_stb = 1'b1;
                     end else begin
                        c_bus = q_reg.e2;
                        q_next.a = c_bus;
                     end
                     q_next.disp = c_bus;
                     q_next.st = ST_FETCH;
                  end
                  OP_REG: begin
                     unique case (sub)
                        RS_INCA: begin
                           s_bus = q_reg.a;
                           c_bus = s_bus + 16'h0001;
                           q_next.a = c_bus;
                        end
                        RS_INCB: begin
                           s_bus = q_reg.b;
                           c_bus = s_bus + 16'h0001;
                           q_next.b = c_bus;
                        end
                        RS_INCX: begin
                           s_bus = q_reg.x;
                           c_bus = s_bus + 16'h0001;
                           q_next.x = c_bus;
                        end
                        RS_DECA: begin
                           s_bus = q_reg.a;
                           c_bus = s_bus - 16'h0001;
                           q_next.a = c_bus;
                        end
                        RS_CPLA: begin
                           s_bus = q_reg.a;
                           c_bus = ~s_bus;
                           q_next.a = c_bus;
                        end
                        RS_A2BX: begin
                           s_bus = q_reg.a;
                           c_bus = s_bus;
                           q_next.b = c_bus;
                           q_next.x = c_bus;
                        end
                        RS_XCHG: begin
                           s_bus = q_reg.x;
                           c_bus = s_bus;
                           q_next.a = c_bus;
                        end
                        RS_HALT: begin
                           c_bus = q_reg.p;
                        end
                     endcase
                     q_next.disp = c_bus;
                     q_next.st = (sub == RS_HALT) ? ST_HALT : ST_FETCH;
                  end
                  default: begin
                     q_next.l = ea;
                     q_next.req = 1'b1;
                     q_next.we = 1'b0;
                     q_next.oe = 1'b0;
                     q_next.st = ST_OWAIT;
                  end
               endcase
            end
            ST_OWAIT: begin
               if (q_reg.k2) begin
                  q_next.w = q_reg.d2;
                  q_next.req = 1'b0;
                  q_next.st = ST_OLOAD;
               end
            end
            ST_OLOAD: begin
               q_next.r = q_reg.w;
               q_next.st = ST_EXEC;
            end
            ST_SWAIT: begin
               if (q_reg.k2) begin
                  q_next.req = 1'b0;
                  q_next.we = 1'b0;
                  q_next.oe = 1'b0;
                  q_next.st = ST_FETCH;
               end
            end
            ST_EXEC: begin
               q_next.st = ST_FETCH;
               s_bus = q_reg.a;
               unique case (op)
                  OP_LDA: c_bus = q_reg.r;
                  OP_LDB: c_bus = q_reg.r;
                  OP_LDX: c_bus = q_reg.r;
                  OP_ADD: begin
                     sum = {1'b0, s_bus} + {1'b0, q_reg.r};
                     c_bus = sum[15:0];
                     if (s_bus[15] == q_reg.r[15] &&
                         c_bus[15] != s_bus[15]) begin
                        q_next.ov = 1'b1;
                     end
                  end
                  OP_SUB: begin
                     diff = {1'b0, s_bus} - {1'b0, q_reg.r};
                     c_bus = diff[15:0];
                     if (s_bus[15] != q_reg.r[15] &&
                         c_bus[15] != s_bus[15]) begin
                        q_next.ov = 1'b1;
                     end
                  end
                  OP_AND: c_bus = s_bus & q_reg.r;
                  OP_IOR: c_bus = s_bus | q_reg.r;
                  OP_MUL: begin
                     c_bus = WORD_RST;
                     sc_load = 1'b1;
                     sc_val = MULDIV_STEPS;
                     q_next.st = ST_MULDIV;
                  end
                  OP_DIV: begin
                     c_bus = s_bus;
                     // A quotient that cannot fit is flagged, not run.
                     if (q_reg.r == WORD_RST || s_bus >= q_reg.r) begin
                        q_next.ov = 1'b1;
                     end else begin
                        sc_load = 1'b1;
                        sc_val = MULDIV_STEPS;
                        q_next.st = ST_MULDIV;
                     end
                  end
                  OP_OUTM: begin
                     c_bus = q_reg.r;
                     q_next.io_out = c_bus;
                     q_next.io_stb = 1'b1;
                  end
                  default: c_bus = s_bus;
               endcase
               q_next.disp = c_bus;
               unique case (op)
                  OP_LDB: q_next.b = c_bus;
                  OP_LDX: q_next.x = c_bus;
                  OP_LDA, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_MUL:
                     q_next.a = c_bus;
                  default: q_next.a = q_reg.a;
               endcase
            end
            ST_MULDIV: begin
               if (sc_zero) begin
                  q_next.disp = q_reg.a;
                  q_next.st = ST_FETCH;
               end else begin
                  sc_step = 1'b1;
                  if (op == OP_MUL) begin
                     // Shift-add: multiplier drains from the extension.
                     sum = {1'b0, q_reg.a} +
                           (q_reg.b[0] ? {1'b0, q_reg.r} : 17'h0_0000);
                     q_next.a = sum[16:1];
                     q_next.b = {sum[0], q_reg.b[15:1]};
                  end else begin
                     // Restoring divide: quotient in B, remainder in A.
                     as = {q_reg.a[14:0], q_reg.b[15]};
                     bs = {q_reg.b[14:0], 1'b0};
                     diff = {q_reg.a[15], as} - {1'b0, q_reg.r};
                     if (!diff[16]) begin
                        q_next.a = diff[15:0];
                        q_next.b = {bs[15:1], 1'b1};
                     end else begin
                        q_next.a = as;
                        q_next.b = bs;
                     end
                  end
               end
            end
            ST_SHIFT: begin
               // One position per base tick stretches execution by count.
               if (sc_zero) begin
                  q_next.disp = q_reg.a;
                  q_next.st = ST_FETCH;
               end else begin
                  sc_step = 1'b1;
                  if (q_reg.u[PAIR_BIT]) begin
                     if (q_reg.u[DIR_BIT]) begin
                        {q_next.a, q_next.b} = {q_reg.a, q_reg.b} << 1;
                     end else begin
                        {q_next.a, q_next.b} = {q_reg.a, q_reg.b} >> 1;
                     end
                  end else if (q_reg.u[DIR_BIT]) begin
                     q_next.a = {q_reg.a[14:0], 1'b0};
                  end else begin
                     q_next.a = {1'b0, q_reg.a[15:1]};
                  end
               end
            end
            ST_HALT: begin
               q_next.st = ST_HALT;
            end
         endcase
      end
      q_next.hlt = (q_next.st == ST_HALT);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q_reg <= '0;
         q_reg.st <= ST_FETCH;
         q_reg.p <= PC_RST;
      end else if (ce) begin
         q_reg <= q_next;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign mem_addr = q_reg.l;
   assign mem_data_out = q_reg.w;
   assign mem_data_oe = q_reg.oe;
   assign mem_req = q_reg.req;
   assign mem_we = q_reg.we;
   assign io_out = q_reg.io_out;
   assign io_strobe = q_reg.io_stb;
   assign display = q_reg.disp;
   assign overflow = q_reg.ov;
   assign halted = q_reg.hlt;

endmodule // cpudp_top

// *** core/cpudp_pkg.sv ***
// Shared constants, opcodes and state type of the processor datapath.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package cpudp_pkg;

   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int MCLK_HZ = 25_000_000;
   localparam int SYS_CLK_HZ = 4_400_000;
   // A phase accumulator keeps the exact base rate on average; single
   // ticks jitter by one master period, which no sequencing step sees.
   localparam int SYS_ACC_STEP = SYS_CLK_HZ / 100_000;
   localparam int SYS_ACC_MOD = MCLK_HZ / 100_000;
   localparam logic [7:0] SYS_ACC_INC = 8'(SYS_ACC_STEP);
   localparam logic [7:0] SYS_ACC_WRAP = 8'(SYS_ACC_MOD - SYS_ACC_STEP);
   localparam logic [7:0] SYS_ACC_RST = 8'h00;

   // -------------------------------------------------------------------
   // Instruction fields and widths
   // -------------------------------------------------------------------
   localparam int OPF_HI = 15;
   localparam int OPF_LO = 12;
   localparam int MF_HI = 11;
   localparam int MF_LO = 9;
   localparam int ADF_HI = 8;
   localparam int DIR_BIT = 8;
   localparam int PAIR_BIT = 7;
   localparam int SUBF_HI = 8;
   localparam int SUBF_LO = 6;
   localparam int CNTF_HI = 4;
   localparam int SC_W = 5;

   // -------------------------------------------------------------------
   // Reset values and counts
   // -------------------------------------------------------------------
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [SC_W-1:0] SC_RST = 5'h00;
   localparam logic [SC_W-1:0] MULDIV_STEPS = 5'h10;

   // -------------------------------------------------------------------
   // Opcodes
   // -------------------------------------------------------------------
   localparam logic [3:0] OP_LDA = 4'h0;
   localparam logic [3:0] OP_LDB = 4'h1;
   localparam logic [3:0] OP_LDX = 4'h2;
   localparam logic [3:0] OP_STA = 4'h3;
   localparam logic [3:0] OP_ADD = 4'h4;
   localparam logic [3:0] OP_SUB = 4'h5;
   localparam logic [3:0] OP_AND = 4'h6;
   localparam logic [3:0] OP_IOR = 4'h7;
   localparam logic [3:0] OP_JMP = 4'h8;
   localparam logic [3:0] OP_JOF = 4'h9;
   localparam logic [3:0] OP_MUL = 4'hA;
   localparam logic [3:0] OP_DIV = 4'hB;
   localparam logic [3:0] OP_SHF = 4'hC;
   localparam logic [3:0] OP_IOA = 4'hD;
   localparam logic [3:0] OP_OUTM = 4'hE;
   localparam logic [3:0] OP_REG = 4'hF;

   // Addressing modes in the mode field.
   localparam logic [2:0] AM_DIRECT = 3'h0;
   localparam logic [2:0] AM_REL = 3'h1;
   localparam logic [2:0] AM_IDX_X = 3'h2;
   localparam logic [2:0] AM_IDX_B = 3'h3;

   // Register-change sub-operations.
   localparam logic [2:0] RS_INCA = 3'h0;
   localparam logic [2:0] RS_INCB = 3'h1;
   localparam logic [2:0] RS_INCX = 3'h2;
   localparam logic [2:0] RS_DECA = 3'h3;
   localparam logic [2:0] RS_CPLA = 3'h4;
   localparam logic [2:0] RS_A2BX = 3'h5;
   localparam logic [2:0] RS_XCHG = 3'h6;
   localparam logic [2:0] RS_HALT = 3'h7;

   typedef enum logic [3:0] {
      ST_FETCH, ST_FWAIT, ST_FLOAD, ST_DEC, ST_OWAIT, ST_OLOAD,
      ST_EXEC, ST_SWAIT, ST_MULDIV, ST_SHIFT, ST_HALT
   } cpudp_state_t;

endpackage

// *** core/cpudp_timing.sv ***
// Base system clock enable generated from the master clock.
`timescale 1ns/1ps
module cpudp_timing
   import cpudp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   output logic tick
);

   typedef struct packed {
      logic [7:0] acc;
      logic tick;
   } cpudp_tim_t;

   cpudp_tim_t q_reg;
   cpudp_tim_t q_next;

   always_comb begin
      q_next = q_reg;
      q_next.tick = 1'b0;
      if (q_reg.acc >= SYS_ACC_WRAP) begin
         q_next.acc = q_reg.acc - SYS_ACC_WRAP;
         q_next.tick = 1'b1;
      end else begin
         q_next.acc = q_reg.acc + SYS_ACC_INC;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q_reg <= '{acc: SYS_ACC_RST, tick: 1'b0};
      end else if (ce) begin
         q_reg <= q_next;
      end
   end

   assign tick = q_reg.tick;

endmodule // cpudp_timing

// *** core/cpudp_shcnt.sv ***
// Five-bit shift counter used by shift, multiply and divide.
`timescale 1ns/1ps
module cpudp_shcnt
   import cpudp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic load,
   input wire logic [SC_W-1:0] load_val,
   input wire logic step,
   output logic [SC_W-1:0] count,
   output logic zero
);

   typedef struct packed {
      logic [SC_W-1:0] cnt;
   } cpudp_sc_t;

   cpudp_sc_t q_reg;
   cpudp_sc_t q_next;

   always_comb begin
      q_next = q_reg;
      if (load) begin
         q_next.cnt = load_val;
      end else if (step && q_reg.cnt != SC_RST) begin
         q_next.cnt = q_reg.cnt - 5'h01;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q_reg <= '{cnt: SC_RST};
      end else if (ce) begin
         q_reg <= q_next;
      end
   end

   assign count = q_reg.cnt;
   assign zero = (q_reg.cnt == SC_RST);

endmodule // cpudp_shcnt

// *** tb/cpudp_assertions.sv ***
// Port-level checks of the processor datapath memory and output handshakes.
`timescale 1ns/1ps
module cpudp_assertions (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_data_out,
   input wire logic mem_data_oe,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_done,
   input wire logic [15:0] io_out,
   input wire logic io_strobe,
   input wire logic overflow,
   input wire logic halted
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // A finished access leaves the bus quiet until a later base tick.
   sequence s_idle4;
      !mem_req [*4];
   endsequence
   a_reset_clear: assert property (disable iff (1'b0) rst |=>
      mem_addr == 16'h0000 && !mem_req && !overflow && !halted)
      else $error("state not cleared by reset");
   a_req_hold: assert property (mem_req && !mem_done |=>
      mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("request dropped before acknowledge");
   a_oe_write: assert property (mem_data_oe |-> mem_req && mem_we)
      else $error("data bus driven outside a write");
   a_wdata_stable: assert property (mem_data_oe && $past(mem_data_oe)
      |-> $stable(mem_data_out))
      else $error("write data moved during a write");
   a_no_early_req: assert property ($rose(mem_req) |->
      !$past(mem_done))
      else $error("new request while memory still answers");
   a_done_seen: assert property ($fell(mem_req) |->
      $past(mem_done, 2))
      else $error("request ended without acknowledge");
   a_tick_gap: assert property ($fell(mem_req) |=> s_idle4)
      else $error("requests closer than one base tick");
   a_strobe_one: assert property (io_strobe |=> !io_strobe)
      else $error("output strobe longer than one cycle");
   a_out_hold: assert property ($changed(io_out) |-> io_strobe)
      else $error("output word changed without strobe");
   a_halt_quiet: assert property (halted |=> halted && !mem_req)
      else $error("fetch after halt");
endmodule // cpudp_assertions

bind cpudp_top cpudp_assertions u_cpudp_assertions (.mclk(mclk),
   .rst(rst), .mem_addr(mem_addr), .mem_data_out(mem_data_out),
   .mem_data_oe(mem_data_oe), .mem_req(mem_req), .mem_we(mem_we),
   .mem_done(mem_done), .io_out(io_out), .io_strobe(io_strobe),
   .overflow(overflow), .halted(halted));

// *** tb/cpudp_mem.sv ***
// Behavioural core memory answering four-phase requests.
`timescale 1ns/1ps
module cpudp_mem (
   input wire logic mclk,
   input wire logic req,
   input wire logic we,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   output logic [15:0] rdata,
   output logic done
);
   logic [15:0] ram [0:511];
   int lat = 0;
   int n = 0;
   initial begin
      rdata = 16'h5a5a;
      done = 1'b0;
   end
   // The address is only taken in, never driven back.
   always @(posedge mclk) begin
      if (req && !done) begin
         n <= n + 1;
         if (n == lat)
            rdata <= we ? ~rdata : ram[addr[8:0]];
         if (n == lat + 1) begin
            if (we)
               ram[addr[8:0]] <= wdata;
            done <= 1'b1;
         end
      end else if (!req) begin
         // Released lines must not keep the old word for the core to see.
         if (done)
            rdata <= ~rdata;
         done <= 1'b0;
         n <= 0;
      end
   end
endmodule // cpudp_mem

// *** tb/test_cpu_register_datapath_fetch.sv ***
// Self-checking testbench of the processor datapath.
`timescale 1ns/1ps
module test_cpu_register_datapath_fetch;
   import cpudp_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [15:0] io_in = 16'h1357;
   logic [15:0] mem_addr, mem_data_in, mem_data_out, io_out, display;
   logic mem_data_oe, mem_req, mem_we, mem_done, io_strobe, overflow, halted;
   logic [15:0] prog[$];
   int n_fail = 0;
   int cmp_count = 0;
   int n_strobe = 0;
   logic [15:0] out_disp = 16'h0000;
   cpudp_top u_cpudp_top (.mclk(mclk), .rst(rst), .ce(ce),
      .mem_addr(mem_addr), .mem_data_in(mem_data_in),
      .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
      .mem_req(mem_req), .mem_we(mem_we), .mem_done(mem_done),
      .io_in(io_in), .io_out(io_out), .io_strobe(io_strobe),
      .display(display), .overflow(overflow), .halted(halted));
   cpudp_mem u_cpudp_mem (.mclk(mclk), .req(mem_req), .we(mem_we),
      .addr(mem_addr), .wdata(mem_data_out), .rdata(mem_data_in),
      .done(mem_done));
   initial begin
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (rst) begin
         n_strobe <= 0;
         out_disp <= 16'h0000;
      end else if (io_strobe === 1'b1) begin
         n_strobe <= n_strobe + 1;
         out_disp <= display;
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (n_fail == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic load();
      for (int i = 0; i < 512; i++)
         u_cpudp_mem.ram[i] = (i < prog.size()) ? prog[i] : 16'h0000;
   endtask
   // Reset for eight cycles, hold ce low for twenty, then run until the core halts.
   task automatic go(input int lat);
      int i;
      u_cpudp_mem.lat = lat;
      rst = 1'b1;
      repeat (8) @(negedge mclk);
      check(mem_addr, 16'h0000);
      check({14'h0000, mem_req, overflow}, 16'h0000);
      rst = 1'b0;
      ce = 1'b0;
      repeat (20) @(negedge mclk);
      check({15'h0000, mem_req}, 16'h0000);
      ce = 1'b1;
      for (i = 0; i < 3000 && halted !== 1'b1; i++)
         @(negedge mclk);
      if (i == 3000) begin
         n_fail++;
         $display("BAD %0t no halt", $time);
         finish_test();
      end
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_addr_modes();
      prog = '{16'h0064, 16'h4065, 16'h3066, 16'h2067, 16'h34c8,
               16'h3214, 16'hf1c0};
      load();
      u_cpudp_mem.ram[100] = 16'h7fff;
      u_cpudp_mem.ram[101] = 16'h0001;
      u_cpudp_mem.ram[103] = 16'h000a;
      go(0);
      check(u_cpudp_mem.ram[102], 16'h8000);
      check(u_cpudp_mem.ram[210], 16'h8000);
      check(u_cpudp_mem.ram[26], 16'h8000);
      check({15'h0000, overflow}, 16'h0001);
   endtask
   task automatic t_mul_shift();
      prog = '{16'h1064, 16'ha065, 16'h3066, 16'hc190, 16'h3067,
               16'hb068, 16'h3069, 16'hc003, 16'h306a, 16'hf1c0};
      load();
      u_cpudp_mem.ram[100] = 16'h1234;
      u_cpudp_mem.ram[101] = 16'h0100;
      u_cpudp_mem.ram[104] = 16'h5000;
      go(6);
      check(u_cpudp_mem.ram[102], 16'h0012);
      check(u_cpudp_mem.ram[103], 16'h3400);
      check(u_cpudp_mem.ram[105], 16'h2000);
      check(u_cpudp_mem.ram[106], 16'h0400);
   endtask
   task automatic t_io_jump();
      prog = '{16'h0064, 16'h8003, 16'hd100, 16'hf000, 16'hd100,
               16'h9009, 16'hd000, 16'h3066, 16'hf1c0, 16'hd100};
      load();
      u_cpudp_mem.ram[100] = 16'hbeef;
      go(2);
      check(io_out, 16'hbef0);
      check(out_disp, 16'hbef0);
      check(16'(n_strobe), 16'h0001);
      check(u_cpudp_mem.ram[102], 16'h1357);
   endtask
   initial begin
      t_addr_modes();
      t_mul_shift();
      t_io_jump();
      finish_test();
   end
endmodule // test_cpu_register_datapath_fetch
